//--- src/cis_pkg.sv
// Shared constants and types for the interrupt entry and return sequencer.
package cis_pkg;

  // Stack pointer value after reset.
  localparam logic [15:0] SP_RESET = 16'h00ff;
  // Top of the vector table; vector n sits at this address minus twice n.
  localparam logic [15:0] VEC_TOP = 16'hfffe;
  // Vector number used by the software trap and debug-injected traps.
  localparam logic [7:0] TRAP_VEC_NUM = 8'h01;
  // Vector number given to peripheral source index zero.
  localparam logic [7:0] SRC_VEC_BASE = 8'h02;
  // Position of the global mask bit inside the condition code register.
  localparam int CCR_MASK_POS = 3;
  // Last step index of a five-byte stack frame.
  localparam logic [2:0] FRAME_LAST = 3'h4;
  // Last step index of the three-byte instruction queue fill.
  localparam logic [2:0] FILL_LAST = 3'h2;
  // Last step index of the two-byte vector fetch.
  localparam logic [2:0] VEC_LAST = 3'h1;
  // Largest number of peripheral sources the vector table can hold.
  localparam int MAX_SRC = 30;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STACK,
    ST_VEC,
    ST_VWAIT,
    ST_UNSTACK,
    ST_UWAIT,
    ST_FILL,
    ST_FWAIT
  } cis_state_t;

  // Destination tag carried alongside each outstanding memory read.
  typedef enum logic [3:0] {
    TG_NONE,
    TG_VHI,
    TG_VLO,
    TG_CCR,
    TG_ACC,
    TG_IDX,
    TG_PCH,
    TG_PCL,
    TG_FILL
  } cis_tag_t;

endpackage

//--- src/cis_req_if.sv
// Interface between the status flag bank and the sequencer.
`timescale 1ns/100ps
interface cis_req_if #(
  parameter int N = 24,
  parameter int IW = 5
);
  logic [N-1:0] flags;    // Sticky status flags, one per source.
  logic [N-1:0] enables;  // Local interrupt enables.
  logic extSet;           // Edge seen on the external request pin.
  logic extHold;          // Asserted pin level in edge-and-level mode.
  logic pending;          // Some enabled flag is set.
  logic [IW-1:0] winIdx;  // Index of the highest-priority enabled flag.

  modport bank (input enables, input extSet, input extHold, output flags, output pending, output winIdx);
  modport seq (output enables, output extSet, output extHold, input flags, input pending, input winIdx);
endinterface

//--- src/cis_flag_bank.sv
// Sticky source flags with local enables and a fixed priority encoder.
`timescale 1ns/100ps
module cis_flag_bank #(
  parameter int N = 24,
  parameter int IW = 5,
  parameter int EXT_IDX = 0
) (
  input wire logic clk_sys,
  input wire logic rstnInt,
  input wire logic [N-1:0] srcEvent,
  input wire logic [N-1:0] flagClear,
  cis_req_if.bank rq
);

  logic [N-1:0] flags_q;  // Flag storage.
  logic [N-1:0] setVec;   // Set requests of this cycle.
  logic [N-1:0] live;     // Flags whose enable is on.

  // Collect set requests; the external pin feeds its own slot.
  always_comb begin
    setVec = srcEvent;
    setVec[EXT_IDX] = srcEvent[EXT_IDX] | rq.extSet | rq.extHold;
  end

  // A set in the same cycle as a clear wins, and flags hold until cleared.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flagClear) | setVec;
    end
  end

  assign live = flags_q & rq.enables;
  assign rq.flags = flags_q;
  assign rq.pending = |live;

  // Lowest index wins; scanning downward leaves the lowest set index.
  always_comb begin
    rq.winIdx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (live[i]) begin
        rq.winIdx = IW'(i);
      end
    end
  end

endmodule

//--- src/cis_sequencer.sv
// Interrupt entry and return sequencer with external request pin logic.
//
// Summary of operation
// - Source events set read-only status flags.
// - Requests forwarded only while local enable set.
// - Maskable requests taken only when mask clear.
// - Mask bit comes up set after reset.
// - Current instruction finishes before entry begins.
// - Stack, mask, fetch vector, prefetch three bytes.
// - Hardware and trap share one entry sequence.
// - Clearing mask inside routine allows nesting.
// - Return restores CONDITION_CODE_REG, accumulator, index low, PC.
// - Index high never saved or restored.
// - Highest priority pending source serviced first.
// - SP names next free byte; PROGRAM_COUNTER_LOW first.
// - SP ends one below the stacked CONDITION_CODE_REG.
// - Stacked PC is the next instruction address.
// - Return unstacks in reverse, refills three bytes.
// - Synchronous pin watch, edge-only or edge-and-level.
// - Asynchronous pin path wakes device from stop.
// - Stack order PROGRAM_COUNTER_LOW, PROGRAM_COUNTER_HIGH, X, A, CONDITION_CODE_REG.
// - Vector high byte at lower address.
// - Pin acts as request only when enabled.
`timescale 1ns/100ps
module cis_sequencer #(
  parameter int NUM_SRC = 24,
  parameter int EXT_IDX = 0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [NUM_SRC-1:0] srcEvent,
  input wire logic [NUM_SRC-1:0] srcEnable,
  input wire logic [NUM_SRC-1:0] flagClear,
  output logic [NUM_SRC-1:0] flagStatus,
  input wire logic instrBoundary,
  input wire logic softwareTrapOpcode,
  input wire logic debugTrap,
  input wire logic returnFromTrapOp,
  input wire logic maskSetReq,
  input wire logic maskClearReq,
  input wire logic [15:0] pcNext,
  input wire logic [7:0] accIn,
  input wire logic [7:0] idxLowIn,
  input wire logic [7:0] conditionCodeRegIn,
  input wire logic spLoad,
  input wire logic [15:0] spLoadValue,
  output logic [15:0] stackPointer,
  output logic globalMask,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrite,
  output logic memRead,
  input wire logic [7:0] memRdData,
  output logic busy,
  output logic entryDone,
  output logic returnDone,
  output logic restoreValid,
  output logic [7:0] conditionCodeRegOut,
  output logic [7:0] accOut,
  output logic [7:0] idxLowOut,
  output logic [15:0] programCounter,
  output logic fetchValid,
  output logic [7:0] fetchData,
  input wire logic extRequestPin,
  input wire logic extRequestPinEnable,
  input wire logic extRequestLevelMode,
  input wire logic extRequestRiseActive,
  input wire logic stopMode,
  output logic wakeRequest
);

  // Width of a source index.
  localparam int IW = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  // Refuse source counts the vector table cannot hold.
  if (NUM_SRC < 1 || NUM_SRC > cis_pkg::MAX_SRC || EXT_IDX >= NUM_SRC) begin : g_bad_param
    $error("cis_sequencer: source count or external index out of range.");
  end

  logic rstSync1_q, rstSync2_q;        // Reset release synchroniser.
  logic rstnInt;                       // Internal reset, released on the clock.
  logic pinSync1_q, pinSync2_q;        // Pin synchroniser stages.
  logic pinPrev_q;                     // Previous asserted state of the pin.
  logic pinAsserted;                   // Pin at its asserted level.
  logic wakeAsyncSet;                  // Raw asynchronous wake term.
  logic mask_q;                        // Global mask bit.
  cis_pkg::cis_state_t state_q;        // Sequencer state.
  logic [2:0] cnt_q;                   // Step within the current state.
  logic isReturn_q;                    // Sequence in progress is a return.
  logic [15:0] sp_q;                   // Stack pointer.
  logic [15:0] savedPc_q;              // Captured next-instruction address.
  logic [7:0] savedAcc_q, savedIdx_q;  // Captured accumulator and index low.
  logic [7:0] savedCcr_q;              // Captured condition codes.
  logic [7:0] vecNum_q;                // Vector number being fetched.
  logic [15:0] vecAddr;                // Address of the vector high byte.
  cis_pkg::cis_tag_t tag1_q, tag2_q;   // Read tag pipeline.
  logic trapReq;                       // Trap instruction or debug trap.
  logic hwTake;                        // Qualified hardware request taken.
  logic takeEntry, takeReturn;         // Boundary decisions.
  logic tagsEmpty;                     // No read outstanding.

  cis_req_if #(.N(NUM_SRC), .IW(IW)) rq ();

  cis_flag_bank #(.N(NUM_SRC), .IW(IW), .EXT_IDX(EXT_IDX)) u_flags (
    .clk_sys(clk_sys),
    .rstnInt(rstnInt),
    .srcEvent(srcEvent),
    .flagClear(flagClear),
    .rq(rq)
  );

  // Release the reset through two flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstnInt = rstSync2_q;

  // Two-stage synchroniser on the external request pin.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
    end else begin
      pinSync1_q <= extRequestPin;
      pinSync2_q <= pinSync1_q;
    end
  end

  // The asserted level follows the selected polarity.
  assign pinAsserted = extRequestRiseActive ? pinSync2_q : ~pinSync2_q;

  // Remember the last asserted state for edge detection.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      pinPrev_q <= 1'b0;
    end else begin
      pinPrev_q <= pinAsserted;
    end
  end

  // Edges always count; the level also counts in edge-and-level mode.
  assign rq.extSet = extRequestPinEnable & pinAsserted & ~pinPrev_q;
  assign rq.extHold = extRequestPinEnable & extRequestLevelMode & pinAsserted;
  assign rq.enables = srcEnable;

  // Wake path that needs no clock: the raw pin sets the flag directly.
  assign wakeAsyncSet = stopMode & extRequestPinEnable & (extRequestPin ~^ extRequestRiseActive);

  // Wake flag, set asynchronously and cleared on the clock once stop ends.
  always_ff @(posedge clk_sys or negedge rstnInt or posedge wakeAsyncSet) begin
    if (!rstnInt) begin
      wakeRequest <= 1'b0;
    end else if (wakeAsyncSet) begin
      wakeRequest <= 1'b1;
    end else if (!stopMode) begin
      wakeRequest <= 1'b0;
    end
  end

  // Boundary decisions: traps first, then hardware, then a return.
  assign trapReq = softwareTrapOpcode | debugTrap;
  assign hwTake = rq.pending & ~mask_q;
  assign takeEntry = (state_q == cis_pkg::ST_IDLE) & instrBoundary & (trapReq | hwTake);
  assign takeReturn = (state_q == cis_pkg::ST_IDLE) & instrBoundary & returnFromTrapOp & ~takeEntry;
  assign tagsEmpty = (tag1_q == cis_pkg::TG_NONE) & (tag2_q == cis_pkg::TG_NONE);
  assign vecAddr = cis_pkg::VEC_TOP - {7'h00, vecNum_q, 1'b0};

  // Global mask: set by reset and entry, restored on return, else software.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      mask_q <= 1'b1;
    end else if (takeEntry) begin
      mask_q <= 1'b1;
    end else if (tag2_q == cis_pkg::TG_CCR) begin
      mask_q <= memRdData[cis_pkg::CCR_MASK_POS];
    end else if (maskClearReq) begin
      mask_q <= 1'b0;
    end else if (maskSetReq) begin
      mask_q <= 1'b1;
    end
  end

  // Capture the registers to stack and the vector to fetch at the boundary.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      savedPc_q <= '0;
      savedAcc_q <= '0;
      savedIdx_q <= '0;
      savedCcr_q <= '0;
      vecNum_q <= cis_pkg::TRAP_VEC_NUM;
    end else if (takeEntry) begin
      savedPc_q <= pcNext;
      savedAcc_q <= accIn;
      savedIdx_q <= idxLowIn;
      savedCcr_q <= conditionCodeRegIn;
      savedCcr_q[cis_pkg::CCR_MASK_POS] <= mask_q;
      if (trapReq) begin
        vecNum_q <= cis_pkg::TRAP_VEC_NUM;
      end else begin
        vecNum_q <= 8'(rq.winIdx) + cis_pkg::SRC_VEC_BASE;
      end
    end
  end

  // Main sequence: issues stack writes and tagged reads, moves the pointer.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      state_q <= cis_pkg::ST_IDLE;
      cnt_q <= '0;
      isReturn_q <= 1'b0;
      sp_q <= cis_pkg::SP_RESET;
      memAddr <= '0;
      memWrData <= '0;
      memWrite <= 1'b0;
      memRead <= 1'b0;
      tag1_q <= cis_pkg::TG_NONE;
      busy <= 1'b0;
    end else begin
      memWrite <= 1'b0;
      memRead <= 1'b0;
      tag1_q <= cis_pkg::TG_NONE;
      case (state_q)
        cis_pkg::ST_IDLE: begin
          cnt_q <= '0;
          if (spLoad) begin
            sp_q <= spLoadValue;
          end
          if (takeEntry) begin
            state_q <= cis_pkg::ST_STACK;
            isReturn_q <= 1'b0;
            busy <= 1'b1;
          end else if (takeReturn) begin
            state_q <= cis_pkg::ST_UNSTACK;
            isReturn_q <= 1'b1;
            busy <= 1'b1;
          end
        end
        cis_pkg::ST_STACK: begin
          // Write at the free byte, then step down.
          memWrite <= 1'b1;
          memAddr <= sp_q;
          sp_q <= sp_q - 16'h0001;
          case (cnt_q)
            3'h0: memWrData <= savedPc_q[7:0];
            3'h1: memWrData <= savedPc_q[15:8];
            3'h2: memWrData <= savedIdx_q;
            3'h3: memWrData <= savedAcc_q;
            default: memWrData <= savedCcr_q;
          endcase
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == cis_pkg::FRAME_LAST) begin
            cnt_q <= '0;
            state_q <= cis_pkg::ST_VEC;
          end
        end
        cis_pkg::ST_VEC: begin
          // High byte first, at the lower address.
          memRead <= 1'b1;
          memAddr <= vecAddr + {13'h0000, cnt_q};
          tag1_q <= (cnt_q == 3'h0) ? cis_pkg::TG_VHI : cis_pkg::TG_VLO;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == cis_pkg::VEC_LAST) begin
            cnt_q <= '0;
            state_q <= cis_pkg::ST_VWAIT;
          end
        end
        cis_pkg::ST_UNSTACK: begin
          // Step up, then read, undoing the stacking order.
          memRead <= 1'b1;
          memAddr <= sp_q + 16'h0001;
          sp_q <= sp_q + 16'h0001;
          case (cnt_q)
            3'h0: tag1_q <= cis_pkg::TG_CCR;
            3'h1: tag1_q <= cis_pkg::TG_ACC;
            3'h2: tag1_q <= cis_pkg::TG_IDX;
            3'h3: tag1_q <= cis_pkg::TG_PCH;
            default: tag1_q <= cis_pkg::TG_PCL;
          endcase
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == cis_pkg::FRAME_LAST) begin
            cnt_q <= '0;
            state_q <= cis_pkg::ST_UWAIT;
          end
        end
        cis_pkg::ST_VWAIT, cis_pkg::ST_UWAIT: begin
          // The fill address is only known once the last read is back.
          if (tagsEmpty) begin
            state_q <= cis_pkg::ST_FILL;
          end
        end
        cis_pkg::ST_FILL: begin
          memRead <= 1'b1;
          memAddr <= programCounter + {13'h0000, cnt_q};
          tag1_q <= cis_pkg::TG_FILL;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == cis_pkg::FILL_LAST) begin
            cnt_q <= '0;
            state_q <= cis_pkg::ST_FWAIT;
          end
        end
        cis_pkg::ST_FWAIT: begin
          if (tagsEmpty) begin
            state_q <= cis_pkg::ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state_q <= cis_pkg::ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Second tag stage lines up with the read data from memory.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      tag2_q <= cis_pkg::TG_NONE;
    end else begin
      tag2_q <= tag1_q;
    end
  end

  // Steer returning read data to the vector, restored registers or queue.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      programCounter <= '0;
      conditionCodeRegOut <= '0;
      accOut <= '0;
      idxLowOut <= '0;
      restoreValid <= 1'b0;
      fetchValid <= 1'b0;
      fetchData <= '0;
    end else begin
      restoreValid <= 1'b0;
      fetchValid <= 1'b0;
      case (tag2_q)
        cis_pkg::TG_VHI: programCounter[15:8] <= memRdData;
        cis_pkg::TG_VLO: programCounter[7:0] <= memRdData;
        cis_pkg::TG_CCR: conditionCodeRegOut <= memRdData;
        cis_pkg::TG_ACC: accOut <= memRdData;
        cis_pkg::TG_IDX: idxLowOut <= memRdData;
        cis_pkg::TG_PCH: programCounter[15:8] <= memRdData;
        cis_pkg::TG_PCL: begin
          programCounter[7:0] <= memRdData;
          restoreValid <= 1'b1;
        end
        cis_pkg::TG_FILL: begin
          fetchValid <= 1'b1;
          fetchData <= memRdData;
        end
        default: begin
        end
      endcase
    end
  end

  // One-cycle completion pulses as the sequencer returns to idle.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      entryDone <= 1'b0;
      returnDone <= 1'b0;
    end else begin
      entryDone <= (state_q == cis_pkg::ST_FWAIT) & tagsEmpty & ~isReturn_q;
      returnDone <= (state_q == cis_pkg::ST_FWAIT) & tagsEmpty & isReturn_q;
    end
  end

  // Registered copies of internal state for the outputs.
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      stackPointer <= cis_pkg::SP_RESET;
      globalMask <= 1'b1;
      flagStatus <= '0;
    end else begin
      stackPointer <= sp_q;
      globalMask <= mask_q;
      flagStatus <= rq.flags;
    end
  end

endmodule

//--- testbench/cis_mem_model.sv
// Behavioural memory on the far side of the sequencer's memory strobes.
`timescale 1ns/100ps
module cis_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWrite,
  input wire logic memRead,
  output logic [7:0] memRdData
);
  // Whole address space; vector and program bytes follow a fixed pattern.
  logic [7:0] mem [0:65535];

  // Content of an unwritten byte, so the bench can predict vectors and fills.
  function automatic logic [7:0] pattern(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Preload the pattern; vector high byte sits at the even address.
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = pattern(16'(a));
    memRdData = 8'h00;
  end

  // Read data is valid only in the cycle after the strobe, else it toggles.
  always @(posedge clk_sys) begin
    if (memWrite) mem[memAddr] <= memWrData;
    if (memRead) memRdData <= mem[memAddr];
    else memRdData <= ~memRdData;
  end
endmodule

//--- testbench/cis_sequencer_checker.sv
// Concurrent checks on the sequencer's top-level ports.
`timescale 1ns/100ps
module cis_sequencer_checker #(
  parameter int NUM_SRC = 24,
  parameter int EXT_IDX = 0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [NUM_SRC-1:0] srcEvent,
  input wire logic [NUM_SRC-1:0] flagClear,
  input wire logic [NUM_SRC-1:0] flagStatus,
  input wire logic instrBoundary,
  input wire logic softwareTrapOpcode,
  input wire logic debugTrap,
  input wire logic returnFromTrapOp,
  input wire logic [15:0] stackPointer,
  input wire logic globalMask,
  input wire logic [15:0] memAddr,
  input wire logic memWrite,
  input wire logic memRead,
  input wire logic busy,
  input wire logic entryDone,
  input wire logic returnDone,
  input wire logic fetchValid,
  input wire logic extRequestPin,
  input wire logic extRequestPinEnable,
  input wire logic extRequestRiseActive,
  input wire logic stopMode,
  input wire logic wakeRequest
);
  // Fill bytes seen since the last finished sequence.
  logic [2:0] fillCnt_q;
  // Event bits that set flags directly; the pin flag goes through a synchroniser.
  localparam logic [NUM_SRC-1:0] EV_MASK = ~(NUM_SRC'(1) << EXT_IDX);

  // Count fill bytes, restarting when a sequence completes.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fillCnt_q <= 3'h0;
    end else if (entryDone || returnDone) begin
      fillCnt_q <= 3'h0;
    end else if (fetchValid) begin
      fillCnt_q <= fillCnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Five pushes, each one byte below the one before.
  sequence s_push;
    memWrite ##1 (memWrite && memAddr == $past(memAddr) - 16'h1) [*4];
  endsequence
  // Two vector reads, high byte at the even table address.
  sequence s_vec;
    memRead && memAddr[15:6] == 10'h3ff && !memAddr[0] ##1 memRead && memAddr == $past(memAddr) + 16'h1;
  endsequence
  // An idle, masked boundary that carries no trap and no return.
  sequence s_bare;
    !busy && instrBoundary && !softwareTrapOpcode && !debugTrap && !returnFromTrapOp && globalMask;
  endsequence

  AST_ENTRY_WALK: assert property ($rose(busy) && !$past(returnFromTrapOp) |=> s_push ##1 s_vec)
    else $error("entry stacking or vector fetch out of order");
  AST_RESET_STATE: assert property (disable iff (1'b0) !rstn ##1 !rstn |-> globalMask && stackPointer == 16'h00ff)
    else $error("mask or stack pointer wrong in reset");
  AST_MASK_BLOCKS: assert property (s_bare ##1 globalMask |-> !busy)
    else $error("masked request was taken");
  AST_TRAP_TAKEN: assert property (!busy && instrBoundary && (softwareTrapOpcode || debugTrap) |=> busy)
    else $error("trap not taken at boundary");
  AST_FILL_THREE: assert property (entryDone || returnDone |-> fillCnt_q + 3'(fetchValid) == 3'h3)
    else $error("fill byte count not three");
  AST_FETCH_AFTER_READ: assert property (fetchValid |-> $past(memRead, 2))
    else $error("fill byte without read");
  AST_IDLE_QUIET: assert property (!busy |-> !memWrite && !memRead)
    else $error("memory strobe while idle");
  AST_FLAG_STICKY: assert property ((($past(flagStatus) & ~$past(flagClear, 2)) & ~flagStatus) == '0)
    else $error("flag dropped without clear");
  AST_FLAG_SET: assert property ((($past(srcEvent, 2) & EV_MASK) & ~flagStatus) == '0)
    else $error("event did not set flag");
  AST_WAKE: assert property (stopMode && extRequestPinEnable && extRequestPin == extRequestRiseActive
    |=> wakeRequest || !stopMode)
    else $error("pin did not wake from stop");
endmodule

bind cis_sequencer cis_sequencer_checker #(.NUM_SRC(NUM_SRC), .EXT_IDX(EXT_IDX)) chk (.*);

//--- testbench/cis_sequencer_tb_top.sv
// Self-checking bench for the interrupt entry and return sequencer.
`timescale 1ns/100ps
module cis_sequencer_tb_top;
  localparam int N = 24;
  logic clk_sys = 1'h0, rstn = 1'h0;
  logic [N-1:0] srcEvent = '0, srcEnable = '0, flagClear = '0, flagStatus;
  logic instrBoundary = 1'h0, softwareTrapOpcode = 1'h0, debugTrap = 1'h0, returnFromTrapOp = 1'h0;
  logic maskSetReq = 1'h0, maskClearReq = 1'h0, spLoad = 1'h0, stopMode = 1'h0;
  logic [15:0] pcNext = '0, spLoadValue = '0, stackPointer, memAddr, programCounter, expPc, sp;
  logic [7:0] accIn = '0, idxLowIn = '0, conditionCodeRegIn = '0, memWrData, memRdData;
  logic [7:0] conditionCodeRegOut, accOut, idxLowOut, fetchData;
  logic globalMask, memWrite, memRead, busy, entryDone, returnDone, restoreValid, fetchValid, wakeRequest, mk;
  logic extRequestPin = 1'h0, extRequestPinEnable = 1'h0, extRequestLevelMode = 1'h0, extRequestRiseActive = 1'h1;
  int fail_count = 0, check_count = 0, fi = 0;
  // Saved frames: program counter, accumulator, index low and stacked flags.
  logic [15:0] pcS [2];
  logic [7:0] aS [2], xS [2], cS [2];

  always #20 clk_sys = ~clk_sys;

  cis_sequencer #(.NUM_SRC(N), .EXT_IDX(0)) DUT (.*);
  cis_mem_model mdl (.*);

  // Compare one value and count the result.
  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One-cycle pulse on a vector input.
  task automatic pulse(ref logic [N-1:0] s, input logic [N-1:0] v);
    @(negedge clk_sys) s = v;
    @(negedge clk_sys) s = '0;
  endtask

  // Software clear of the global mask.
  task automatic clrMask;
    @(negedge clk_sys) maskClearReq = 1'h1;
    @(negedge clk_sys) maskClearReq = 1'h0;
    mk = 1'h0;
  endtask

  // Present one boundary and wait, bounded, for any started sequence to end.
  task automatic run(input logic t, d, r, output logic took);
    @(negedge clk_sys);
    {instrBoundary, softwareTrapOpcode, debugTrap, returnFromTrapOp} = {1'h1, t, d, r};
    fi = 0;
    @(negedge clk_sys);
    {instrBoundary, softwareTrapOpcode, debugTrap, returnFromTrapOp} = 4'h0;
    took = busy;
    for (int i = 0; i < 60 && busy !== 1'h0; i++) @(negedge clk_sys);
    if (took) chk("fills", 16'(fi), 16'h3);
  endtask

  // Entry with random CPU state; checks the frame, the pointer and the mask.
  task automatic entry(input int j, input logic t, d, input logic [7:0] vn);
    logic took;
    logic [15:0] va;
    va = cis_pkg::VEC_TOP - 16'(2 * vn);
    expPc = {mdl.pattern(va), mdl.pattern(va + 16'h1)};
    pcS[j] = {1'h1, 15'($urandom)};
    aS[j] = 8'($urandom);
    xS[j] = 8'($urandom);
    cS[j] = 8'($urandom);
    {pcNext, accIn, idxLowIn, conditionCodeRegIn} = {pcS[j], aS[j], xS[j], cS[j]};
    cS[j][cis_pkg::CCR_MASK_POS] = mk;
    run(t, d, 1'h0, took);
    chk("entry", took, 16'h1);
    chk("pcl", mdl.mem[sp], pcS[j][7:0]);
    chk("pch", mdl.mem[sp - 16'h1], pcS[j][15:8]);
    chk("idx", mdl.mem[sp - 16'h2], xS[j]);
    chk("acc", mdl.mem[sp - 16'h3], aS[j]);
    chk("ccr", mdl.mem[sp - 16'h4], cS[j]);
    sp = sp - 16'h5;
    chk("sp", stackPointer, sp);
    mk = 1'h1;
    chk("mask", globalMask, 16'h1);
  endtask

  // Return; checks restored state, pointer and mask.
  task automatic ret(input int j);
    logic took;
    expPc = pcS[j];
    run(1'h0, 1'h0, 1'h1, took);
    chk("ret", took, 16'h1);
    chk("ccrOut", conditionCodeRegOut, cS[j]);
    chk("accOut", accOut, aS[j]);
    chk("idxOut", idxLowOut, xS[j]);
    chk("pcOut", programCounter, pcS[j]);
    sp = sp + 16'h5;
    chk("spRet", stackPointer, sp);
    mk = cS[j][cis_pkg::CCR_MASK_POS];
    chk("maskRet", globalMask, 16'(mk));
  endtask

  // Every fill byte must come from the expected program address.
  always @(negedge clk_sys) begin
    if (fetchValid === 1'h1) begin
      chk("fetch", fetchData, mdl.pattern(expPc + 16'(fi)));
      fi++;
    end
  end

  // Main sequence.
  initial begin
    logic took;
    int k1, k2;
    k1 = $urandom(32'h51410972);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk("maskRst", globalMask, 16'h1);
    chk("spRst", stackPointer, cis_pkg::SP_RESET);
    mk = 1'h1;
    sp = 16'h0180 + 16'($urandom_range(63));
    spLoadValue = sp;
    spLoad = 1'h1;
    @(negedge clk_sys) spLoad = 1'h0;
    k1 = $urandom_range(N - 3, 1);
    k2 = $urandom_range(N - 2, k1 + 1);
    srcEnable = (N'(1) << k1) | (N'(1) << k2);
    pulse(srcEvent, srcEnable | (N'(1) << (N - 1)));
    run(1'h0, 1'h0, 1'h0, took);
    chk("masked", took, 16'h0);
    chk("flags", flagStatus[k1] & flagStatus[k2] & flagStatus[N-1], 16'h1);
    clrMask;
    entry(0, 1'h0, 1'h0, cis_pkg::SRC_VEC_BASE + 8'(k1));
    pulse(flagClear, N'(1) << k1);
    clrMask;
    entry(1, 1'h0, 1'h0, cis_pkg::SRC_VEC_BASE + 8'(k2));
    pulse(flagClear, N'(1) << k2);
    ret(1);
    ret(0);
    clrMask;
    run(1'h0, 1'h0, 1'h0, took);
    chk("disabled", took, 16'h0);
    pulse(flagClear, N'(1) << (N - 1));
    for (int i = 0; i < 2; i++) begin
      entry(0, i == 0, i == 1, cis_pkg::TRAP_VEC_NUM);
      ret(0);
    end
    srcEnable[0] = 1'h1;
    extRequestPin = 1'h1;
    repeat (5) @(negedge clk_sys);
    chk("pinOff", flagStatus[0], 16'h0);
    extRequestPin = 1'h0;
    extRequestPinEnable = 1'h1;
    repeat (5) @(negedge clk_sys);
    extRequestPin = 1'h1;
    repeat (5) @(negedge clk_sys);
    chk("pinEdge", flagStatus[0], 16'h1);
    extRequestLevelMode = 1'h1;
    pulse(flagClear, N'(1));
    repeat (3) @(negedge clk_sys);
    chk("pinLevel", flagStatus[0], 16'h1);
    extRequestPin = 1'h0;
    repeat (4) @(negedge clk_sys);
    pulse(flagClear, N'(1));
    repeat (3) @(negedge clk_sys);
    chk("pinClr", flagStatus[0], 16'h0);
    stopMode = 1'h1;
    extRequestPin = 1'h1;
    @(negedge clk_sys);
    chk("wake", wakeRequest, 16'h1);
    stopMode = 1'h0;
    extRequestPin = 1'h0;
    conclude;
  end

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk_sys);
    fail_count++;
    conclude;
  end
endmodule
